// file: rtl/iar_pkg.sv
package iar_pkg;

	// receive ports, each with its own copy of the alias entries
	localparam int IAR_NUM_PORTS   = 2;
	localparam int IAR_PORT_W      = 1;
	localparam int IAR_NUM_ENTRIES = 5;
	localparam int IAR_ENTRY_W     = 3;
	localparam int IAR_ADDR_W      = 7;
	localparam int IAR_DATA_W      = 8;

	typedef logic [IAR_ADDR_W-1:0]  iar_addr_t;
	typedef logic [IAR_DATA_W-1:0]  iar_byte_t;
	typedef logic [IAR_ENTRY_W-1:0] iar_idx_t;

	// register offsets, entries 3 to 7
	localparam iar_byte_t IAR_OFS_ENTRY_3 = 8'h68;
	localparam iar_byte_t IAR_OFS_ENTRY_4 = 8'h69;
	localparam iar_byte_t IAR_OFS_ENTRY_5 = 8'h6a;
	localparam iar_byte_t IAR_OFS_ENTRY_6 = 8'h6b;
	localparam iar_byte_t IAR_OFS_ENTRY_7 = 8'h6c;

	// number of the first entry held here
	localparam iar_idx_t  IAR_FIRST_ENTRY = 3'h3;

	// field layout and reset value of an entry
	localparam int        IAR_ALIAS_MSB   = 7;
	localparam int        IAR_ALIAS_LSB   = 1;
	localparam int        IAR_AUTO_ACK    = 0;
	localparam int        IAR_RW_BIT      = 0;
	localparam iar_byte_t IAR_ENTRY_RST   = 8'h00;
	localparam iar_addr_t IAR_ALIAS_OFF   = 7'h00;
	localparam iar_byte_t IAR_READ_IDLE   = 8'h00;

	// offset to entry index; valid flag in the top bit
	function automatic logic [IAR_ENTRY_W:0] iar_decode(input iar_byte_t ofs);
		unique case (ofs)
			IAR_OFS_ENTRY_3: iar_decode = {1'b1, 3'h0};
			IAR_OFS_ENTRY_4: iar_decode = {1'b1, 3'h1};
			IAR_OFS_ENTRY_5: iar_decode = {1'b1, 3'h2};
			IAR_OFS_ENTRY_6: iar_decode = {1'b1, 3'h3};
			IAR_OFS_ENTRY_7: iar_decode = {1'b1, 3'h4};
			default:         iar_decode = {1'b0, 3'h0};
		endcase
	endfunction : iar_decode

endpackage : iar_pkg

// file: rtl/iar_match_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iar_match_if;
	import iar_pkg::*;

	iar_byte_t entry [IAR_NUM_ENTRIES];
	iar_addr_t phys  [IAR_NUM_ENTRIES];
	iar_byte_t addr_byte;
	logic      hit;
	iar_idx_t  idx;
	iar_addr_t remap;
	logic      auto_ack;

	modport owner (
		output entry, phys, addr_byte,
		input  hit, idx, remap, auto_ack
	);
	modport matcher (
		input  entry, phys, addr_byte,
		output hit, idx, remap, auto_ack
	);
endinterface : iar_match_if
`default_nettype wire

// file: rtl/iar_alias_match.sv
`timescale 1ns/1ps
`default_nettype none
module iar_alias_match
	import iar_pkg::*;
(
	iar_match_if.matcher m
);
	iar_addr_t incoming;
	logic      is_write;

	// address bits only; direction bit does not take part
	assign incoming = m.addr_byte[IAR_ALIAS_MSB:IAR_ALIAS_LSB]; // RL7
	assign is_write = ~m.addr_byte[IAR_RW_BIT];

	always_comb begin
		m.hit      = 1'b0;
		m.idx      = '0;
		m.remap    = '0;
		m.auto_ack = 1'b0;
		// lowest entry wins when two aliases are equal
		for (int i = IAR_NUM_ENTRIES - 1; i >= 0; i--) begin
			if (m.entry[i][IAR_ALIAS_MSB:IAR_ALIAS_LSB] != IAR_ALIAS_OFF && // RL3
			    m.entry[i][IAR_ALIAS_MSB:IAR_ALIAS_LSB] == incoming) begin // RL1
				m.hit      = 1'b1;
				m.idx      = iar_idx_t'(i);
				m.remap    = m.phys[i]; // RL2
				m.auto_ack = is_write & m.entry[i][IAR_AUTO_ACK]; // RL4
			end
		end
	end
endmodule : iar_alias_match
`default_nettype wire

// file: rtl/iar_alias_remap.sv
// Operation
// (RL1) each entry 3..7 holds a 7-bit alias in bits 7:1, reset zero, compared
// (RL2) on alias match the paired physical target address replaces the address
// (RL3) alias value zero disables the entry: no detect, no forward
// (RL4) bit 0 set auto-acknowledges writes to that target regardless of link
// (RL5) one copy of every entry per receive port, accessed via port select
// (RL6) paired target setting bits 7:1 hold the physical 7-bit target address
// (RL7) alias compare uses only the 7 address bits, ignoring read/write
`timescale 1ns/1ps
`default_nettype none
module iar_alias_remap
	import iar_pkg::*;
(
	// clock and reset
	input  wire logic                                   clk_in,
	input  wire logic                                   rst_n_in,
	// register access from the local i2c target logic
	input  wire logic [IAR_PORT_W-1:0]                  port_sel_in,
	input  wire logic [IAR_DATA_W-1:0]                  reg_addr_in,
	input  wire logic [IAR_DATA_W-1:0]                  reg_wdata_in,
	input  wire logic                                   reg_wr_in,
	input  wire logic                                   reg_rd_in,
	output logic      [IAR_DATA_W-1:0]                  reg_rdata_out,
	output logic                                        reg_hit_out,
	// physical target settings, bits 7:1 of each, per port and entry
	input  wire logic [IAR_NUM_PORTS-1:0][IAR_NUM_ENTRIES-1:0][IAR_DATA_W-1:0] remote_physical_addr_in,
	// first byte of a local i2c transaction
	input  wire logic                                   addr_valid_in,
	input  wire logic [IAR_DATA_W-1:0]                  addr_byte_in,
	// forward path, one lane per receive port
	output logic      [IAR_NUM_PORTS-1:0]               fwd_valid_out,
	output logic      [IAR_NUM_PORTS-1:0][IAR_DATA_W-1:0] fwd_byte_out,
	output logic      [IAR_NUM_PORTS-1:0][IAR_ENTRY_W-1:0] fwd_entry_out,
	output logic      [IAR_NUM_PORTS-1:0]               auto_ack_out
);

	// entry storage, one copy per port
	iar_byte_t entry      [IAR_NUM_PORTS][IAR_NUM_ENTRIES];
	iar_byte_t next_entry [IAR_NUM_PORTS][IAR_NUM_ENTRIES];

	// register read answer
	iar_byte_t next_rdata;
	logic      next_hit;

	// forward path state
	logic      [IAR_NUM_PORTS-1:0]               next_fwd_valid;
	logic      [IAR_NUM_PORTS-1:0][IAR_DATA_W-1:0] next_fwd_byte;
	logic      [IAR_NUM_PORTS-1:0][IAR_ENTRY_W-1:0] next_fwd_entry;
	logic      [IAR_NUM_PORTS-1:0]               next_auto_ack;

	logic      [IAR_ENTRY_W:0]                   dec;
	iar_idx_t                                    sel_idx;
	logic                                        sel_ok;

	assign dec     = iar_decode(reg_addr_in);
	assign sel_ok  = dec[IAR_ENTRY_W];
	assign sel_idx = dec[IAR_ENTRY_W-1:0];

	// register writes land only in the selected port's copy
	always_comb begin
		for (int p = 0; p < IAR_NUM_PORTS; p++) begin
			for (int e = 0; e < IAR_NUM_ENTRIES; e++) begin
				next_entry[p][e] = entry[p][e];
				if (reg_wr_in && sel_ok && port_sel_in == IAR_PORT_W'(p) &&
				    sel_idx == iar_idx_t'(e)) begin // RL5
					next_entry[p][e] = reg_wdata_in; // RL1 RL4
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < IAR_NUM_PORTS; p++) begin
				for (int e = 0; e < IAR_NUM_ENTRIES; e++) begin
					entry[p][e] <= IAR_ENTRY_RST; // RL1
				end
			end
		end else begin
			entry <= next_entry;
		end
	end

	// reads return the selected port's copy, unmapped offsets read zero
	always_comb begin
		next_rdata = IAR_READ_IDLE;
		next_hit   = 1'b0;
		if (reg_rd_in && sel_ok) begin
			next_rdata = entry[port_sel_in][sel_idx]; // RL5
			next_hit   = 1'b1;
		end else if (reg_wr_in && sel_ok) begin
			next_hit   = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= IAR_READ_IDLE;
			reg_hit_out   <= 1'b0;
		end else begin
			reg_rdata_out <= next_rdata;
			reg_hit_out   <= next_hit;
		end
	end

	// one alias decoder per receive port
	logic      [IAR_NUM_PORTS-1:0]               m_hit;
	logic      [IAR_NUM_PORTS-1:0]               m_auto;
	logic      [IAR_NUM_PORTS-1:0][IAR_ADDR_W-1:0] m_remap;
	logic      [IAR_NUM_PORTS-1:0][IAR_ENTRY_W-1:0] m_idx;

	for (genvar p = 0; p < IAR_NUM_PORTS; p++) begin : g_port
		iar_match_if mif ();

		for (genvar e = 0; e < IAR_NUM_ENTRIES; e++) begin : g_entry
			assign mif.entry[e] = entry[p][e];
			// physical address sits in bits 7:1 of its setting
			assign mif.phys[e]  =
				remote_physical_addr_in[p][e][IAR_ALIAS_MSB:IAR_ALIAS_LSB]; // RL6
		end
		assign mif.addr_byte = addr_byte_in;

		iar_alias_match u_match (
			.m (mif.matcher)
		);

		assign m_hit[p]   = mif.hit;
		assign m_auto[p]  = mif.auto_ack;
		assign m_remap[p] = mif.remap;
		assign m_idx[p]   = mif.idx;
	end

	// forward the remapped first byte, direction bit kept
	always_comb begin
		for (int p = 0; p < IAR_NUM_PORTS; p++) begin
			next_fwd_valid[p] = 1'b0;
			next_fwd_byte[p]  = fwd_byte_out[p];
			next_fwd_entry[p] = fwd_entry_out[p];
			next_auto_ack[p]  = 1'b0;
			if (addr_valid_in && m_hit[p]) begin // RL3
				next_fwd_valid[p] = 1'b1;
				next_fwd_byte[p]  = {m_remap[p], addr_byte_in[IAR_RW_BIT]}; // RL2 RL7
				next_fwd_entry[p] = IAR_ENTRY_W'(m_idx[p] + IAR_FIRST_ENTRY);
				next_auto_ack[p]  = m_auto[p]; // RL4
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fwd_valid_out <= '0;
			fwd_byte_out  <= '0;
			fwd_entry_out <= '0;
			auto_ack_out  <= '0;
		end else begin
			fwd_valid_out <= next_fwd_valid;
			fwd_byte_out  <= next_fwd_byte;
			fwd_entry_out <= next_fwd_entry;
			auto_ack_out  <= next_auto_ack;
		end
	end

endmodule : iar_alias_remap
`default_nettype wire

// file: dv/iar_alias_remap_props.sv
`timescale 1ns/1ps
`default_nettype none
module iar_chk
	import iar_pkg::*;
(
	input wire logic            clk_in,
	input wire logic            rst_n_in,
	input wire logic [7:0]      reg_addr_in,
	input wire logic            reg_wr_in,
	input wire logic            reg_rd_in,
	input wire logic            reg_hit_out,
	input wire logic            addr_valid_in,
	input wire logic [7:0]      addr_byte_in,
	input wire logic [1:0]      fwd_valid_out,
	input wire logic [1:0][7:0] fwd_byte_out,
	input wire logic [1:0][2:0] fwd_entry_out,
	input wire logic [1:0]      auto_ack_out
);
	wire logic acc = (reg_wr_in || reg_rd_in) && reg_addr_in inside {[8'h68:8'h6c]};
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_hit_late: assert property (acc |=> reg_hit_out)
		else $error("no hit after mapped access");
	chk_hit_cause: assert property (reg_hit_out |-> $past(acc))
		else $error("hit without mapped access");
	chk_fwd_cause: assert property (|fwd_valid_out |-> $past(addr_valid_in))
		else $error("forward without address byte");
	chk_zero_off: assert property (addr_valid_in && addr_byte_in[7:1] == 7'h00
		|=> fwd_valid_out == 2'b00)
		else $error("address zero forwarded");
	chk_ack_write: assert property (|auto_ack_out
		|-> (auto_ack_out & ~fwd_valid_out) == 2'b00 && !$past(addr_byte_in[0]))
		else $error("auto ack off a forwarded write");
	chk_rw_kept: assert property (fwd_valid_out[0]
		|-> fwd_byte_out[0][0] == $past(addr_byte_in[0]))
		else $error("read write bit changed");
	chk_entry_num: assert property (fwd_valid_out[1]
		? fwd_entry_out[1] inside {[3'h3:3'h7]} : $stable(fwd_entry_out[1]))
		else $error("entry number out of range or moved without match");
	chk_byte_hold: assert property (!fwd_valid_out[0] |-> $stable(fwd_byte_out[0]))
		else $error("forward byte moved without match");
endmodule : iar_chk
bind iar_alias_remap iar_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_hit_out(reg_hit_out), .addr_valid_in(addr_valid_in), .addr_byte_in(addr_byte_in),
	.fwd_valid_out(fwd_valid_out), .fwd_byte_out(fwd_byte_out),
	.fwd_entry_out(fwd_entry_out), .auto_ack_out(auto_ack_out));
`default_nettype wire

// file: dv/iar_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module iar_far_end
	import iar_pkg::*;
(
	// physical target settings
	output logic [IAR_NUM_PORTS-1:0][IAR_NUM_ENTRIES-1:0][IAR_DATA_W-1:0] phys_out
);
	// reserved bit 0 high, must not leak into the remap
	always_comb begin
		for (int p = 0; p < IAR_NUM_PORTS; p++)
			for (int e = 0; e < IAR_NUM_ENTRIES; e++)
				phys_out[p][e] = {7'(8'h50 + 8 * p + e), 1'b1};
	end
endmodule : iar_far_end
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import iar_pkg::*;
	logic clk_in = 1'b0, rst_n_in = 1'b0, ps = 1'b0, wr = 1'b0, rd = 1'b0, av = 1'b0, hit;
	iar_byte_t ra = 8'h00, wd = 8'h00, ab = 8'h00, rdat;
	logic [1:0] fv, aa;
	logic [1:0][7:0] fb;
	logic [1:0][2:0] fe;
	logic [1:0][4:0][7:0] phys;
	int errors = 0, total_checks = 0, cyc = 0;
	iar_far_end far (.phys_out(phys));
	iar_alias_remap dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .port_sel_in(ps),
		.reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .reg_hit_out(hit), .remote_physical_addr_in(phys),
		.addr_valid_in(av), .addr_byte_in(ab), .fwd_valid_out(fv), .fwd_byte_out(fb),
		.fwd_entry_out(fe), .auto_ack_out(aa));
	function automatic iar_addr_t pa(input int p, e);
		return 7'(8'h50 + 8 * p + e);
	endfunction : pa
	task automatic cmp(input logic [7:0] g, e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic acc(input logic p, w, input iar_byte_t a, d);
		@(negedge clk_in);
		{ps, ra, wd, wr, rd} = {p, a, d, w, !w};
		@(negedge clk_in);
		{wr, rd} = 2'b00;
	endtask : acc
	task automatic send(input iar_byte_t b);
		@(negedge clk_in);
		{av, ab} = {1'b1, b};
		@(negedge clk_in);
		av = 1'b0;
	endtask : send
	task automatic t_reset;
		for (int i = 0; i < 10; i++) begin
			acc(i[0], 1'b0, 8'(8'h68 + i / 2), 8'h00);
			cmp(rdat, IAR_ENTRY_RST);
			cmp({7'h00, hit}, 8'h01);
		end
		$display("done reset");
	endtask : t_reset
	task automatic t_regs;
		for (int i = 0; i < 10; i++)
			acc(i[0], 1'b1, 8'(8'h68 + i / 2), 8'(12 * i + 128));
		cmp({7'h00, hit}, 8'h01);
		for (int i = 0; i < 10; i++) begin
			acc(i[0], 1'b0, 8'(8'h68 + i / 2), 8'h00);
			cmp(rdat, 8'(12 * i + 128));
		end
		@(negedge clk_in);
		cmp(rdat, 8'h00);
		// write then read back to back on the same entry
		@(negedge clk_in);
		{ps, ra, wd, wr, rd} = {1'b0, 8'h68, 8'h3c, 1'b1, 1'b0};
		@(negedge clk_in);
		{wr, rd} = 2'b01;
		@(negedge clk_in);
		rd = 1'b0;
		cmp(rdat, 8'h3c);
		acc(1'b0, 1'b1, 8'h6d, 8'h5a);
		cmp({7'h00, hit}, 8'h00);
		acc(1'b0, 1'b0, 8'h6d, 8'h00);
		cmp(rdat, 8'h00);
		$display("done regs");
	endtask : t_regs
	task automatic t_remap;
		acc(1'b0, 1'b1, 8'h69, 8'h43);
		acc(1'b0, 1'b1, 8'h6c, 8'h43);
		acc(1'b1, 1'b1, 8'h69, 8'h44);
		send(8'h42);
		cmp({2'h0, fv, 2'h0, aa}, 8'h11);
		cmp(fb[0], {pa(0, 1), 1'b0});
		cmp({5'h00, fe[0]}, 8'h04);
		send(8'h43);
		cmp({2'h0, fv, 2'h0, aa}, 8'h10);
		cmp(fb[0], {pa(0, 1), 1'b1});
		send(8'h44);
		cmp({2'h0, fv, 2'h0, aa}, 8'h20);
		cmp(fb[1], {pa(1, 1), 1'b0});
		cmp({5'h00, fe[1]}, 8'h04);
		$display("done remap");
	endtask : t_remap
	task automatic t_off;
		acc(1'b0, 1'b1, 8'h69, 8'h01);
		send(8'h42);
		cmp({5'h00, fe[0]}, 8'h07);
		acc(1'b0, 1'b1, 8'h6c, 8'h00);
		send(8'h42);
		cmp({2'h0, fv, 2'h0, aa}, 8'h00);
		send(8'h00);
		cmp({2'h0, fv, 2'h0, aa}, 8'h00);
		cmp(fb[0], {pa(0, 4), 1'b0});
		$display("done off");
	endtask : t_off
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial forever #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
		t_reset();
		t_regs();
		t_remap();
		t_off();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
